// ===== hdl/qdsl_fifo.sv
// Synchronous FIFO with valid/ready on both sides
// Assumes one clock; DEPTH a power of two
`timescale 1ns/100ps
module qdsl_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input logic i_clk,
  input logic i_sys_rst,
  input logic i_in_valid,
  output logic o_in_ready,
  input logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("qdsl_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } qdsl_fifo_type;

  qdsl_fifo_type st_r;
  qdsl_fifo_type st_nxt;
  logic push;
  logic pop;

  assign o_in_ready = (st_r.count != (AW + 1)'(DEPTH));
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data = st_r.mem[st_r.rd_ptr];

  always_comb begin
    st_nxt = st_r;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = i_in_data;
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : qdsl_fifo

// ===== hdl/qdsl_loader.sv
// Quad 14-bit DAC serial load path: pin sampling, 24-bit frame capture,
// load queue, per-channel input registers and DAC latches, output clamp,
// and a classic Wishbone slave for control and observation.
// Assumes serial pins asynchronous to i_clk and a serial clock no faster
// than one eighth of i_clk.
//
// What this block does
// RQ1: Latch codes drive outputs as straight binary
// RQ2: Each channel has input register and latch
// RQ3: Clamp low forces outputs to sense ground
// RQ4: Clamp holds until next load strobe assertion or direct latch write
// RQ5: Frame is 8 control plus 16 data
// RQ6: Host sends control bits first
// RQ7: Strobe pulse copies all input registers
// RQ8: Strobe low: frame end writes latch directly
// RQ9: 24-bit shift register keeps newest bits
// RQ10: Accept bit zero ignores the frame
// RQ11: Host sends bit 23 first, descending
// RQ12: Bits 22..21 pick the channel
// RQ13: Bits 20..16 must match package pins
// RQ14: Code taken from bits 13..0
// RQ15: Host pads data field with two zeros
// RQ16: Shift one bit per edge while framed
// RQ17: Rejected frames change no input register or latch
`timescale 1ns/100ps
module qdsl_loader #(
  parameter int FIFO_DEPTH = qdsl_pkg::FIFO_DEPTH
) (
  input logic i_clk,
  input logic i_sys_rst,
  input logic i_serial_clk,
  input logic i_serial_data,
  input logic i_frame_sync_n,
  input logic i_latch_update_strobe_n,
  input logic i_output_clamp_n,
  input logic [qdsl_pkg::PKG_ADDR_BITS-1:0] i_package_id_pins,
  input logic i_wb_cyc,
  input logic i_wb_stb,
  input logic i_wb_we,
  input logic [7:0] i_wb_adr,
  input logic [3:0] i_wb_sel,
  input logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output qdsl_pkg::qdsl_bank_type o_analog_outputs,
  output logic o_sense_ground_level_sel
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("qdsl_loader: FIFO_DEPTH must be at least 2");
  end

  localparam int LW = $bits(qdsl_pkg::qdsl_load_type);

  typedef struct packed {
    logic ctrl_rise;
    logic ctrl_hold;
    logic overflow;
    logic sclk_d;
    logic frame_sync_n_n_d;
    logic strobe_n_d;
    logic [qdsl_pkg::FRAME_BITS-1:0] shreg;
    logic [qdsl_pkg::BITCNT_BITS-1:0] bitcnt;
    logic [qdsl_pkg::FRAME_BITS-1:0] last_frame;
    logic [qdsl_pkg::BITCNT_BITS-1:0] last_bits;
    logic [qdsl_pkg::COUNT_BITS-1:0] cnt_accept;
    logic [qdsl_pkg::COUNT_BITS-1:0] cnt_miss;
    logic [qdsl_pkg::COUNT_BITS-1:0] cnt_ignore;
    qdsl_pkg::qdsl_bank_type inreg;
    qdsl_pkg::qdsl_bank_type latch;
    logic clamp;
    logic wb_ack;
    logic [31:0] wb_dat;
  } qdsl_state_type;

  qdsl_state_type st_r;
  qdsl_state_type st_nxt;
  qdsl_pkg::qdsl_pins_type pins_raw;
  qdsl_pkg::qdsl_pins_type pins;
  qdsl_pkg::qdsl_load_type push_d;
  qdsl_pkg::qdsl_load_type pop_d;
  logic push_v;
  logic push_rdy;
  logic pop_v;
  logic pop_rdy;
  logic [LW-1:0] pop_bits;

  assign pins_raw = '{
    serial_clk: i_serial_clk,
    serial_data: i_serial_data,
    frame_sync_n: i_frame_sync_n,
    latch_update_strobe_n: i_latch_update_strobe_n,
    output_clamp_n: i_output_clamp_n,
    package_id_pins: i_package_id_pins
  };

  qdsl_sync3 #(
    .WIDTH($bits(qdsl_pkg::qdsl_pins_type)),
    .RESET_VALUE(qdsl_pkg::PINS_IDLE)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_raw),
    .o_level(pins)
  );

  // Accepted frames wait here; draining stalls while software holds it
  qdsl_fifo #(
    .WIDTH(LW),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(push_v),
    .o_in_ready(push_rdy),
    .i_in_data(push_d),
    .o_out_valid(pop_v),
    .i_out_ready(pop_rdy),
    .o_out_data(pop_bits)
  );

  assign pop_d = qdsl_pkg::qdsl_load_type'(pop_bits);
  assign pop_rdy = !st_r.ctrl_hold;

  always_comb begin
    logic shift_edge;
    logic frame_start;
    logic frame_end;
    logic strobe_fall;
    logic accept;
    logic addr_ok;
    logic apply;
    logic wb_req;
    logic [qdsl_pkg::CHAN_BITS-1:0] chan;
    logic [3:0] idx;
    st_nxt = st_r;
    shift_edge = 1'b0;
    frame_start = 1'b0;
    frame_end = 1'b0;
    strobe_fall = 1'b0;
    accept = 1'b0;
    addr_ok = 1'b0;
    apply = 1'b0;
    wb_req = 1'b0;
    chan = '0;
    idx = '0;
    push_v = 1'b0;
    push_d = '0;

    st_nxt.sclk_d = pins.serial_clk;
    st_nxt.frame_sync_n_n_d = pins.frame_sync_n;
    st_nxt.strobe_n_d = pins.latch_update_strobe_n;

    // Serial capture
    frame_start = st_r.frame_sync_n_n_d && !pins.frame_sync_n;
    frame_end = !st_r.frame_sync_n_n_d && pins.frame_sync_n;
    if (st_r.ctrl_rise) begin
      shift_edge = pins.serial_clk && !st_r.sclk_d;
    end else begin
      shift_edge = !pins.serial_clk && st_r.sclk_d;
    end
    if (frame_start) begin
      st_nxt.shreg = '0;
      st_nxt.bitcnt = '0;
    end else if (shift_edge && !pins.frame_sync_n) begin // RQ16
      // Older bits fall off the top, so the newest 24 remain
      st_nxt.shreg = {st_r.shreg[qdsl_pkg::FRAME_BITS-2:0], pins.serial_data}; // RQ9
      if (st_r.bitcnt != '1) begin
        st_nxt.bitcnt = st_r.bitcnt + 1'b1;
      end
    end

    // Frame decode at the rising edge of frame sync
    accept = st_r.shreg[qdsl_pkg::ACCEPT_POS]; // RQ10
    addr_ok = (st_r.shreg[qdsl_pkg::PADDR_HI:qdsl_pkg::PADDR_LO]
               == pins.package_id_pins); // RQ13
    if (frame_end) begin
      st_nxt.last_frame = st_r.shreg; // RQ5
      st_nxt.last_bits = st_r.bitcnt;
      if (!accept) begin
        st_nxt.cnt_ignore = st_r.cnt_ignore + 1'b1; // RQ17
      end else if (!addr_ok) begin
        st_nxt.cnt_miss = st_r.cnt_miss + 1'b1; // RQ17
      end else begin
        push_v = 1'b1;
        push_d.chan = st_r.shreg[qdsl_pkg::CHAN_HI:qdsl_pkg::CHAN_LO]; // RQ12
        push_d.code = st_r.shreg[qdsl_pkg::CODE_HI:qdsl_pkg::CODE_LO]; // RQ14
        // Strobe level at frame end decides a direct latch write
        push_d.direct = !pins.latch_update_strobe_n; // RQ8
        if (push_rdy) begin
          st_nxt.cnt_accept = st_r.cnt_accept + 1'b1;
        end else begin
          st_nxt.overflow = 1'b1;
        end
      end
    end

    // Queue drain into the addressed channel
    apply = pop_v && pop_rdy;
    chan = pop_d.chan;
    if (apply) begin
      st_nxt.inreg[chan] = pop_d.code; // RQ2
      if (pop_d.direct) begin
        st_nxt.latch[chan] = pop_d.code; // RQ8
      end
    end

    // Simultaneous update on the strobe's falling edge
    strobe_fall = st_r.strobe_n_d && !pins.latch_update_strobe_n;
    if (strobe_fall) begin
      st_nxt.latch = st_nxt.inreg; // RQ7
    end

    // Output clamp
    if (!pins.output_clamp_n) begin
      st_nxt.clamp = 1'b1; // RQ3
    end else if (strobe_fall || (apply && pop_d.direct)) begin
      st_nxt.clamp = 1'b0; // RQ4
    end

    // Wishbone slave, answers one cycle after the request is seen
    wb_req = i_wb_cyc && i_wb_stb && !st_r.wb_ack;
    st_nxt.wb_ack = wb_req;
    st_nxt.wb_dat = '0;
    idx = i_wb_adr[7:4];
    if (wb_req && i_wb_we) begin
      if (i_wb_adr == qdsl_pkg::ADR_CTRL && i_wb_sel[0]) begin
        st_nxt.ctrl_rise = i_wb_dat[qdsl_pkg::CTRL_RISE_POS];
        st_nxt.ctrl_hold = i_wb_dat[qdsl_pkg::CTRL_HOLD_POS];
      end
      // Write one clears; a new overflow in the same cycle wins
      if (i_wb_adr == qdsl_pkg::ADR_STATUS && i_wb_sel[0]
          && i_wb_dat[qdsl_pkg::STAT_OVF_POS]
          && !(frame_end && accept && addr_ok && !push_rdy)) begin
        st_nxt.overflow = 1'b0;
      end
    end
    if (wb_req && !i_wb_we) begin
      unique case (i_wb_adr)
        qdsl_pkg::ADR_CTRL: begin
          st_nxt.wb_dat[qdsl_pkg::CTRL_RISE_POS] = st_r.ctrl_rise;
          st_nxt.wb_dat[qdsl_pkg::CTRL_HOLD_POS] = st_r.ctrl_hold;
        end
        qdsl_pkg::ADR_STATUS: begin
          st_nxt.wb_dat[qdsl_pkg::STAT_CLAMP_POS] = st_r.clamp;
          st_nxt.wb_dat[qdsl_pkg::STAT_OVF_POS] = st_r.overflow;
          st_nxt.wb_dat[qdsl_pkg::STAT_INFRAME_POS] = !pins.frame_sync_n;
          st_nxt.wb_dat[qdsl_pkg::STAT_STROBE_POS] = !pins.latch_update_strobe_n;
          st_nxt.wb_dat[qdsl_pkg::STAT_EMPTY_POS] = !pop_v;
        end
        qdsl_pkg::ADR_LAST_FRAME: begin
          st_nxt.wb_dat[qdsl_pkg::FRAME_BITS-1:0] = st_r.last_frame;
        end
        qdsl_pkg::ADR_ACCEPT_CNT: begin
          st_nxt.wb_dat[qdsl_pkg::COUNT_BITS-1:0] = st_r.cnt_accept;
        end
        qdsl_pkg::ADR_MISS_CNT: begin
          st_nxt.wb_dat[qdsl_pkg::COUNT_BITS-1:0] = st_r.cnt_miss;
        end
        qdsl_pkg::ADR_IGNORE_CNT: begin
          st_nxt.wb_dat[qdsl_pkg::COUNT_BITS-1:0] = st_r.cnt_ignore;
        end
        qdsl_pkg::ADR_LAST_BITS: begin
          st_nxt.wb_dat[qdsl_pkg::BITCNT_BITS-1:0] = st_r.last_bits;
        end
        default: begin
          if (idx == qdsl_pkg::ADR_INPUT_BASE && i_wb_adr[1:0] == 2'h0) begin
            st_nxt.wb_dat[qdsl_pkg::CODE_BITS-1:0] = st_r.inreg[i_wb_adr[3:2]];
          end else if (idx == qdsl_pkg::ADR_LATCH_BASE && i_wb_adr[1:0] == 2'h0) begin
            st_nxt.wb_dat[qdsl_pkg::CODE_BITS-1:0] = st_r.latch[i_wb_adr[3:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.sclk_d <= qdsl_pkg::PINS_IDLE.serial_clk;
      st_r.frame_sync_n_n_d <= qdsl_pkg::PINS_IDLE.frame_sync_n;
      st_r.strobe_n_d <= qdsl_pkg::PINS_IDLE.latch_update_strobe_n;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Codes leave unchanged: zero is the lower reference, all ones the top step
  assign o_analog_outputs = st_r.latch; // RQ1
  assign o_sense_ground_level_sel = st_r.clamp; // RQ3
  assign o_wb_ack = st_r.wb_ack;
  assign o_wb_dat = st_r.wb_dat;
endmodule : qdsl_loader

// ===== hdl/qdsl_sync3.sv
// Three-stage pin sampler; a change counts once stages two and three agree
// Assumes inputs asynchronous to i_clk
`timescale 1ns/100ps
module qdsl_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input logic i_clk,
  input logic i_sys_rst,
  input logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } qdsl_sync_type;

  qdsl_sync_type st_r;
  qdsl_sync_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, level: RESET_VALUE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;
endmodule : qdsl_sync3

// ===== pkg/qdsl_pkg.sv
// Constants, register map and carrier types of the quad DAC serial loader
// Assumes a 32-bit classic Wishbone register port with byte addresses
package qdsl_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 14;
  localparam int CHANNELS = 4;
  localparam int CHAN_BITS = 2;
  localparam int PKG_ADDR_BITS = 5;
  localparam int ACCEPT_POS = 23;
  localparam int CHAN_HI = 22;
  localparam int CHAN_LO = 21;
  localparam int PADDR_HI = 20;
  localparam int PADDR_LO = 16;
  localparam int CODE_HI = 13;
  localparam int CODE_LO = 0;
  localparam int FIFO_DEPTH = 32;
  localparam int BITCNT_BITS = 8;
  localparam int COUNT_BITS = 16;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_LAST_FRAME = 8'h08;
  localparam logic [7:0] ADR_ACCEPT_CNT = 8'h0c;
  localparam logic [7:0] ADR_MISS_CNT = 8'h10;
  localparam logic [7:0] ADR_IGNORE_CNT = 8'h14;
  localparam logic [7:0] ADR_LAST_BITS = 8'h18;
  localparam logic [3:0] ADR_INPUT_BASE = 4'h2;
  localparam logic [3:0] ADR_LATCH_BASE = 4'h3;
  // Field positions
  localparam int CTRL_RISE_POS = 0;
  localparam int CTRL_HOLD_POS = 1;
  localparam int STAT_CLAMP_POS = 0;
  localparam int STAT_OVF_POS = 1;
  localparam int STAT_INFRAME_POS = 2;
  localparam int STAT_STROBE_POS = 3;
  localparam int STAT_EMPTY_POS = 4;

  typedef logic [CODE_BITS-1:0] qdsl_code_type;
  typedef qdsl_code_type [CHANNELS-1:0] qdsl_bank_type;

  typedef struct packed {
    logic [CHAN_BITS-1:0] chan;
    qdsl_code_type code;
    logic direct;
  } qdsl_load_type;

  typedef struct packed {
    logic serial_clk;
    logic serial_data;
    logic frame_sync_n;
    logic latch_update_strobe_n;
    logic output_clamp_n;
    logic [PKG_ADDR_BITS-1:0] package_id_pins;
  } qdsl_pins_type;

  localparam qdsl_pins_type PINS_IDLE = '{
    serial_clk: 1'b0,
    serial_data: 1'b0,
    frame_sync_n: 1'b1,
    latch_update_strobe_n: 1'b1,
    output_clamp_n: 1'b1,
    package_id_pins: 5'h00
  };
endpackage : qdsl_pkg

// ===== verification/qdsl_host_model.sv
// Host model: drives serial clock, data and frame sync of the loader
// Assumes send is entered just after a rising edge of i_clk
`timescale 1ns/100ps
module qdsl_host_model (
  input wire logic i_clk,
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_frame_sync_n
);
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_frame_sync_n = 1'b1;
  end
  // Each clock level lasts 4 cycles; the clock stands low outside frames
  // Rising-edge mode sets each bit up while the clock stands low
  task automatic send(input logic [31:0] bits, input int n, input logic rise);
    o_frame_sync_n <= 1'b0;
    if (rise) o_serial_data <= bits[n - 1];
    repeat (4) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      if (!rise) o_serial_data <= bits[i];
      o_serial_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_serial_clk <= 1'b0;
      if (rise && i > 0) o_serial_data <= bits[i - 1];
      repeat (4) @(posedge i_clk);
    end
    o_frame_sync_n <= 1'b1;
    // Released data line shows the inverse of its last bit
    o_serial_data <= ~bits[0];
    repeat (8) @(posedge i_clk);
  endtask : send
endmodule : qdsl_host_model

// ===== verification/qdsl_loader_chk.sv
// Checker of the loader ports: bus handshake, reset, latch hold, clamp
// Assumes it is bound to every qdsl_loader instance
`timescale 1ns/100ps
module qdsl_loader_chk (
  input logic i_clk,
  input logic i_sys_rst,
  input logic i_frame_sync_n,
  input logic i_latch_update_strobe_n,
  input logic i_output_clamp_n,
  input logic i_wb_cyc,
  input logic i_wb_stb,
  input logic [31:0] o_wb_dat,
  input logic o_wb_ack,
  input qdsl_pkg::qdsl_bank_type o_analog_outputs,
  input logic o_sense_ground_level_sel
);
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  // Cycles spent inside a frame with the strobe high
  always_comb begin
    quiet_nxt = quiet_r;
    if (i_frame_sync_n || !i_latch_update_strobe_n) quiet_nxt = 4'h0;
    else if (quiet_r != 4'hf) quiet_nxt = quiet_r + 4'h1;
  end
  always_ff @(posedge i_clk) begin
    quiet_r <= i_sys_rst ? 4'h0 : quiet_nxt;
  end
  chk_ack_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  chk_ack_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  chk_ack_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_wb_ack |-> $past(i_wb_cyc) && $past(i_wb_stb)) else $error("stray ack");
  chk_dat_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
  chk_reset_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> o_analog_outputs == '0 && !o_sense_ground_level_sel)
    else $error("outputs not cleared by reset");
  chk_latch_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    quiet_r > 4'ha |-> $stable(o_analog_outputs)) else $error("latch moved in frame");
  chk_clamp_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_output_clamp_n [*7] |-> o_sense_ground_level_sel) else $error("clamp missed");
  chk_clamp_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_latch_update_strobe_n [*8] ##0 o_sense_ground_level_sel) |=>
    o_sense_ground_level_sel) else $error("clamp released early");
endmodule : qdsl_loader_chk
bind qdsl_loader qdsl_loader_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_frame_sync_n(i_frame_sync_n), .i_latch_update_strobe_n(i_latch_update_strobe_n),
  .i_output_clamp_n(i_output_clamp_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_analog_outputs(o_analog_outputs),
  .o_sense_ground_level_sel(o_sense_ground_level_sel));

// ===== verification/qdsl_loader_tb.sv
// Self-checking bench of the loader against an integer model
// Assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
module qdsl_loader_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n = 1'b1;
  logic clamp_n = 1'b1;
  logic [4:0] pid = 5'h00;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic sclk;
  logic sdat;
  logic sync_n;
  logic gsel;
  qdsl_pkg::qdsl_bank_type aout;
  int error_cnt = 0;
  int checks = 0;
  int inreg[4] = '{0, 0, 0, 0};
  int latch[4] = '{0, 0, 0, 0};
  int clamp_m = 0;
  int acc_m = 0;
  int miss_m = 0;
  int ign_m = 0;
  logic rise_m = 1'b0;
  logic [3:0] sel = 4'h0;
  always #5 clk = ~clk;
  qdsl_host_model host (.i_clk(clk), .o_serial_clk(sclk), .o_serial_data(sdat),
    .o_frame_sync_n(sync_n));
  qdsl_loader #(.FIFO_DEPTH(4)) dut (.i_clk(clk), .i_sys_rst(rst), .i_serial_clk(sclk),
    .i_serial_data(sdat), .i_frame_sync_n(sync_n), .i_latch_update_strobe_n(strobe_n),
    .i_output_clamp_n(clamp_n), .i_package_id_pins(pid), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_analog_outputs(aout), .o_sense_ground_level_sel(gsel));
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Request stands until ack is sampled high at a rising edge; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : wb
  task automatic load(input logic acc, input logic [1:0] ch, input logic [4:0] pa,
                      input logic [13:0] code, input logic ext);
    host.send({4'ha, acc, ch, pa, 2'b00, code}, ext ? 28 : 24, rise_m);
    if (!acc) ign_m++;
    else if (pa != pid) miss_m++;
    if (acc && pa == pid) begin
      acc_m++;
      inreg[ch] = code;
      if (!strobe_n) begin
        latch[ch] = code;
        clamp_m = 0;
      end
    end
    repeat (8) @(posedge clk);
  endtask : load
  task automatic pulse;
    strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int c = 0; c < 4; c++) latch[c] = inreg[c];
    clamp_m = 0;
  endtask : pulse
  task automatic chk_all;
    logic [31:0] q;
    for (int c = 0; c < 4; c++) begin
      cmp(32'(aout[c]), 32'(latch[c]));
      wb(1'b0, 8'h20 + 8'(4 * c), 32'h0, q);
      cmp(q, 32'(inreg[c]));
    end
    cmp(32'(gsel), 32'(clamp_m));
  endtask : chk_all
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    logic [31:0] q;
    q = $urandom(35);
    pid <= 5'($urandom);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_all;
    for (int c = 0; c < 4; c++) load(1'b1, 2'(c), pid, 14'($urandom), 1'b0);
    chk_all;
    pulse;
    chk_all;
    strobe_n <= 1'b0;
    load(1'b1, 2'h1, pid, 14'h3fff, 1'b0);
    load(1'b1, 2'h2, pid, 14'h0000, 1'b1);
    chk_all;
    strobe_n <= 1'b1;
    load(1'b0, 2'h0, pid, 14'h1234, 1'b0);
    load(1'b1, 2'h0, pid ^ 5'h01, 14'h2345, 1'b0);
    load(1'b1, 2'h3, pid, 14'($urandom), 1'b1);
    chk_all;
    clamp_n <= 1'b0;
    repeat (8) @(posedge clk);
    clamp_m = 1;
    chk_all;
    clamp_n <= 1'b1;
    load(1'b1, 2'h0, pid, 14'($urandom), 1'b0);
    chk_all;
    pulse;
    chk_all;
    // Shift on the rising serial clock edge
    wb(1'b1, 8'h00, 32'h1, q);
    wb(1'b0, 8'h00, 32'h0, q);
    cmp(q, 32'h1);
    rise_m = 1'b1;
    load(1'b1, 2'h2, pid, 14'($urandom), 1'b0);
    rise_m = 1'b0;
    wb(1'b1, 8'h00, 32'h0, q);
    chk_all;
    // Hold the queue, overfill it, then drain it
    wb(1'b1, 8'h00, 32'h2, q);
    wb(1'b0, 8'h00, 32'h0, q);
    cmp(q, 32'h2);
    for (int i = 1; i <= 5; i++) load(1'b1, 2'h0, pid, 14'(i), 1'b0);
    // The fifth frame finds the queue full and is dropped
    inreg[0] = 4;
    acc_m--;
    wb(1'b0, 8'h04, 32'h0, q);
    cmp(q & 32'h12, 32'h2);
    wb(1'b1, 8'h00, 32'h0, q);
    repeat (10) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0, q);
    cmp(q & 32'h12, 32'h12);
    wb(1'b1, 8'h04, 32'h2, q);
    wb(1'b0, 8'h04, 32'h0, q);
    cmp(q & 32'h12, 32'h10);
    chk_all;
    wb(1'b0, 8'h0c, 32'h0, q);
    cmp(q, 32'(acc_m));
    wb(1'b0, 8'h10, 32'h0, q);
    cmp(q, 32'(miss_m));
    wb(1'b0, 8'h14, 32'h0, q);
    cmp(q, 32'(ign_m));
    wb(1'b0, 8'h18, 32'h0, q);
    cmp(q, 32'h18);
    wb(1'b0, 8'h08, 32'h0, q);
    cmp(q, {8'h00, 1'b1, 2'h0, pid, 2'b00, 14'h0005});
    wb(1'b0, 8'hfc, 32'h0, q);
    cmp(q, 32'h0);
    end_of_test;
  end
endmodule : qdsl_loader_tb
